//--- core/timer_pkg.sv
// Constants shared by the timer time base: register map, fields, resets.
package timer_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses on the APB)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
   localparam logic [7:0] OFF_EVENT_TRIG  = 8'h04;
   localparam logic [7:0] OFF_STATUS_ONE  = 8'h08;
   localparam logic [7:0] OFF_COUNT       = 8'h0C;
   localparam logic [7:0] OFF_PRESCALE    = 8'h10;
   localparam logic [7:0] OFF_RELOAD      = 8'h14;
   localparam logic [7:0] OFF_REPEAT      = 8'h18;
   localparam logic [7:0] OFF_SLAVE_MODE  = 8'h1C;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTL_RUN_BIT     = 0;
   localparam int unsigned CTL_INHIBIT_BIT = 1;
   localparam int unsigned CTL_FILTER_BIT  = 2;
   localparam int unsigned CTL_DIR_BIT     = 4;
   localparam int unsigned CTL_CMS_LSB     = 5;
   localparam int unsigned CTL_RELOAD_BUFFER_ENABLE_BIT    = 7;
   localparam int unsigned EVT_FORCE_BIT   = 0;
   localparam int unsigned STS_FLAG_BIT    = 0;
   localparam int unsigned SLV_SMS_LSB     = 0;
   localparam int unsigned SLV_ECE_BIT     = 3;
   localparam int unsigned SLV_TSEL_BIT    = 4;

   // ---------------------------------------------------------------
   // Encodings and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0]  CMS_EDGE       = 2'h0;
   localparam logic [2:0]  SMS_OFF        = 3'h0;
   localparam logic [2:0]  SMS_RESET      = 3'h4;
   localparam logic [2:0]  SMS_EXT_CLOCK  = 3'h7;
   localparam logic [15:0] RST_RELOAD     = 16'hFFFF;
   localparam logic [15:0] RST_PRESCALE   = 16'h0000;
   localparam logic [15:0] RST_COUNT      = 16'h0000;
   localparam logic [7:0]  RST_REPEAT     = 8'h00;

   // Prescaler clock source, one-hot
   typedef enum logic [3:0] {
      SRC_INTERNAL = 4'b0001,
      SRC_TIMER_PIN = 4'b0010,
      SRC_EXT_TRIG = 4'b0100,
      SRC_INT_TRIG = 4'b1000
   } clk_src_t;

endpackage

//--- core/timer_time_base.sv
// Time base of a 16-bit timer: prescaler, counter, repetition, APB regs.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Down mode counts reload value to zero, reloads, underflows, updates.
// - Force-update bit from software or trigger adds an update event.
// - Update inhibit blocks update events; shadows keep their values except unbuffered reload writes.
// - Down mode force restarts counter at reload value, prescaler at zero.
// - Source filter: forced update updates but leaves update flag clear.
// - Update copies prescale and reload preloads to shadows, sets flag.
// - Reload shadow refreshed before counter reload on same update.
// - Center mode: up to reload minus one, overflow, down to zero, under.
// - Center mode: direction ignores software, shows hardware direction.
// - Center mode force restarts counter and prescaler at zero.
// - Inhibited center mode keeps counting; repeat count acts at once.
// - Center counting starts in the direction last written.
// - Center count write: above reload keeps dir; 0 or reload sets it.
// - Counter-driven updates only when repetition counter is zero.
// - Repetition decrements on overflow, underflow, or both in center.
// - Eight-bit repetition gives at most 128 center-mode periods.
// - Forced update acts at once and reloads the repetition counter.
// - Prescaler source: system clock, timer pin, trigger pin, trigger in.
// - With slave modes off, run/force are software bits, dir too in edge modes; force clears.
// - Internal clock mode: prescaler runs once counter run is written 1.
// - Counter active follows counter run by one clock cycle.
// - Prescaler divides by programmed value plus one.
// - Up mode counts zero to reload value, restarts, overflows, updates.
module timer_time_base
   import timer_pkg::*;
#(
   parameter int unsigned CNT_W = 16,
   parameter int unsigned REP_W = 8
) (
   input  wire logic             CLK_I,
   input  wire logic             RESET_N_I,
   input  wire logic             PSEL_I,
   input  wire logic             PENABLE_I,
   input  wire logic             PWRITE_I,
   input  wire logic [7:0]       PADDR_I,
   input  wire logic [31:0]      PWDATA_I,
   input  wire logic             TIMER_INPUT_PIN_I,
   input  wire logic             EXTERNAL_TRIGGER_PIN_I,
   input  wire logic             INTERNAL_TRIGGER_IN_I,
   input  wire logic             TRIGGER_UPDATE_I,
   output logic      [31:0]      PRDATA_O,
   output logic                  PREADY_O,
   output logic                  PSLVERR_O,
   output logic                  UPDATE_EVENT_O,
   output logic                  UPDATE_FLAG_O,
   output logic                  OVERFLOW_O,
   output logic                  UNDERFLOW_O,
   output logic                  DIRECTION_O,
   output logic                  COUNTER_ACTIVE_O,
   output logic      [CNT_W-1:0] COUNT_VALUE_O
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic             run_ff, inhibit_ff, filter_ff, dir_ff, reload_buffer_enable_ff;
   logic [1:0]       cms_ff;
   logic [2:0]       sms_ff;
   logic             ece_ff, tsel_ff, active_ff, flag_ff;
   logic [CNT_W-1:0] psc_pre_ff, psc_act_ff, psc_cnt_ff;
   logic [CNT_W-1:0] arr_pre_ff, arr_sh_ff, cnt_ff;
   logic [REP_W-1:0] rep_val_ff, rep_cnt_ff;
   logic             ready_ff, slverr_ff, uev_ff, over_ff, under_ff;
   logic [31:0]      rdata_ff, rdata;
   logic [2:0]       sync1_ff, sync2_ff, sync3_ff;
   logic [2:0]       pin_edge;
   logic [2:0]       pin_in;
   logic [CNT_W-1:0] nxt_cnt, nxt_psc_cnt, arr_new, arr_m1;
   logic [REP_W-1:0] nxt_rep_cnt;
   logic             nxt_dir, nxt_flag;
   clk_src_t         src;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   function automatic logic at(input logic [7:0] a, input logic [7:0] o);
      at = (a == o);
   endfunction

   // Writes land at the access edge, when the answer is sampled
   wire setup    = PSEL_I & ~PENABLE_I;
   wire wr       = PSEL_I & PENABLE_I & ready_ff & PWRITE_I;
   wire wr_ctrl  = wr & at(PADDR_I, OFF_CONTROL_ONE);
   wire wr_event = wr & at(PADDR_I, OFF_EVENT_TRIG);
   wire wr_stat  = wr & at(PADDR_I, OFF_STATUS_ONE);
   wire wr_count = wr & at(PADDR_I, OFF_COUNT);
   wire wr_psc   = wr & at(PADDR_I, OFF_PRESCALE);
   wire wr_arr   = wr & at(PADDR_I, OFF_RELOAD);
   wire wr_rep   = wr & at(PADDR_I, OFF_REPEAT);
   wire wr_slave = wr & at(PADDR_I, OFF_SLAVE_MODE);
   wire [CNT_W-1:0] wdata = PWDATA_I[CNT_W-1:0];

   // Read mux; the force bit always reads zero since it clears itself
   always_comb begin
      rdata = 32'h0000_0000;
      if (at(PADDR_I, OFF_CONTROL_ONE)) begin
         rdata[CTL_RUN_BIT]     = run_ff;
         rdata[CTL_INHIBIT_BIT] = inhibit_ff;
         rdata[CTL_FILTER_BIT]  = filter_ff;
         rdata[CTL_DIR_BIT]     = dir_ff;
         rdata[CTL_CMS_LSB+:2]  = cms_ff;
         rdata[CTL_RELOAD_BUFFER_ENABLE_BIT]    = reload_buffer_enable_ff;
      end else if (at(PADDR_I, OFF_STATUS_ONE)) begin
         rdata[STS_FLAG_BIT] = flag_ff;
      end else if (at(PADDR_I, OFF_COUNT)) begin
         rdata[CNT_W-1:0] = cnt_ff;
      end else if (at(PADDR_I, OFF_PRESCALE)) begin
         rdata[CNT_W-1:0] = psc_pre_ff;
      end else if (at(PADDR_I, OFF_RELOAD)) begin
         rdata[CNT_W-1:0] = arr_pre_ff;
      end else if (at(PADDR_I, OFF_REPEAT)) begin
         rdata[REP_W-1:0] = rep_val_ff;
      end else if (at(PADDR_I, OFF_SLAVE_MODE)) begin
         rdata[SLV_SMS_LSB+:3] = sms_ff;
         rdata[SLV_ECE_BIT]    = ece_ff;
         rdata[SLV_TSEL_BIT]   = tsel_ff;
      end
   end

   wire hit = at(PADDR_I, OFF_CONTROL_ONE) | at(PADDR_I, OFF_EVENT_TRIG) |
              at(PADDR_I, OFF_STATUS_ONE) | at(PADDR_I, OFF_COUNT) |
              at(PADDR_I, OFF_PRESCALE) | at(PADDR_I, OFF_RELOAD) |
              at(PADDR_I, OFF_REPEAT) | at(PADDR_I, OFF_SLAVE_MODE);

   // One wait-free access phase: ready rises right after setup
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ready_ff  <= 1'b0;
         slverr_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
      end else begin
         ready_ff  <= setup;
         slverr_ff <= setup & ~hit;
         rdata_ff  <= setup ? rdata : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers and prescaler clock source
   // ---------------------------------------------------------------
   assign pin_in = {INTERNAL_TRIGGER_IN_I, EXTERNAL_TRIGGER_PIN_I,
                    TIMER_INPUT_PIN_I};

   // Two stages before use; third stage only for the rising-edge detect
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
               {sync3_ff[g], sync2_ff[g], sync1_ff[g]} <= 3'h0;
            end else begin
               {sync3_ff[g], sync2_ff[g], sync1_ff[g]} <=
                  {sync2_ff[g], sync1_ff[g], pin_in[g]};
            end
         end
         assign pin_edge[g] = sync2_ff[g] & ~sync3_ff[g];
      end
   endgenerate

   // Source choice; trigger pin mode wins over the slave clock mode
   assign src = ece_ff ? SRC_EXT_TRIG :
                (sms_ff != SMS_EXT_CLOCK) ? SRC_INTERNAL :
                tsel_ff ? SRC_INT_TRIG : SRC_TIMER_PIN;

   wire src_tick = (src == SRC_INTERNAL)  |
                   ((src == SRC_TIMER_PIN) & pin_edge[0]) |
                   ((src == SRC_EXT_TRIG)  & pin_edge[1]) |
                   ((src == SRC_INT_TRIG)  & pin_edge[2]);

   // ---------------------------------------------------------------
   // Count, event and update decode
   // ---------------------------------------------------------------
   wire center   = (cms_ff != CMS_EDGE);
   wire psc_tick = active_ff & src_tick;
   wire cnt_tick = psc_tick & (psc_cnt_ff == psc_act_ff);
   assign arr_m1 = arr_sh_ff - 1'b1;

   wire over  = cnt_tick & ~dir_ff &
                (center ? (cnt_ff == arr_m1) : (cnt_ff == arr_sh_ff));
   wire under = cnt_tick & dir_ff & (cnt_ff == '0);
   wire rep_event = over | under;
   wire rep_zero  = (rep_cnt_ff == '0);

   // Trigger-driven update only comes from the reset slave mode
   wire force_req = (wr_event & PWDATA_I[EVT_FORCE_BIT]) |
                    ((sms_ff == SMS_RESET) & TRIGGER_UPDATE_I);
   wire update_event = ~inhibit_ff &
              (force_req | (rep_event & rep_zero));
   wire flag_set = update_event & ~(force_req & filter_ff);

   // The new reload value is used by the reload on the same edge
   assign arr_new = update_event ? arr_pre_ff : arr_sh_ff;

   // Next count; a software write wins, then a forced restart
   always_comb begin
      nxt_cnt = cnt_ff;
      if (wr_count) begin
         nxt_cnt = wdata;
      end else if (force_req) begin
         nxt_cnt = (center | ~dir_ff) ? '0 : arr_new;
      end else if (cnt_tick) begin
         if (center) begin
            nxt_cnt = (over | (dir_ff & ~under)) ? cnt_ff - 1'b1 :
                      cnt_ff + 1'b1;
         end else if (dir_ff) begin
            nxt_cnt = under ? arr_new : cnt_ff - 1'b1;
         end else begin
            nxt_cnt = over ? '0 : cnt_ff + 1'b1;
         end
      end
   end

   // Direction: software owns it in edge modes, hardware in center mode
   always_comb begin
      nxt_dir = dir_ff;
      if (!center) begin
         if (wr_ctrl) begin
            nxt_dir = PWDATA_I[CTL_DIR_BIT];
         end
      end else if (wr_count) begin
         if (wdata == '0) begin
            nxt_dir = 1'b0;
         end else if (wdata == arr_sh_ff) begin
            nxt_dir = 1'b1;
         end
      end else if (force_req) begin
         nxt_dir = 1'b0;
      end else if (over) begin
         nxt_dir = 1'b1;
      end else if (under) begin
         nxt_dir = 1'b0;
      end
   end

   // Prescaler restarts on a force; the ratio itself waits for an update
   assign nxt_psc_cnt = force_req ? '0 :
                        cnt_tick ? '0 :
                        psc_tick ? psc_cnt_ff + 1'b1 : psc_cnt_ff;

   // Repetition has no preload, so a new count applies at once
   assign nxt_rep_cnt = force_req ? rep_val_ff :
                        rep_event ? (rep_zero ? rep_val_ff :
                                     rep_cnt_ff - 1'b1) : rep_cnt_ff;

   // Set wins over a software clear in the same cycle
   assign nxt_flag = flag_set | (flag_ff & ~(wr_stat &
                     ~PWDATA_I[STS_FLAG_BIT]));

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         run_ff     <= 1'b0;
         inhibit_ff <= 1'b0;
         filter_ff  <= 1'b0;
         cms_ff     <= CMS_EDGE;
         reload_buffer_enable_ff    <= 1'b0;
         sms_ff     <= SMS_OFF;
         ece_ff     <= 1'b0;
         tsel_ff    <= 1'b0;
         active_ff  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            run_ff     <= PWDATA_I[CTL_RUN_BIT];
            inhibit_ff <= PWDATA_I[CTL_INHIBIT_BIT];
            filter_ff  <= PWDATA_I[CTL_FILTER_BIT];
            cms_ff     <= PWDATA_I[CTL_CMS_LSB+:2];
            reload_buffer_enable_ff    <= PWDATA_I[CTL_RELOAD_BUFFER_ENABLE_BIT];
         end
         if (wr_slave) begin
            sms_ff  <= PWDATA_I[SLV_SMS_LSB+:3];
            ece_ff  <= PWDATA_I[SLV_ECE_BIT];
            tsel_ff <= PWDATA_I[SLV_TSEL_BIT];
         end
         active_ff <= run_ff;
      end
   end

   // ---------------------------------------------------------------
   // Time base state, preloads and shadows
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         psc_pre_ff <= RST_PRESCALE;
         psc_act_ff <= RST_PRESCALE;
         psc_cnt_ff <= RST_PRESCALE;
         arr_pre_ff <= RST_RELOAD;
         arr_sh_ff  <= RST_RELOAD;
         rep_val_ff <= RST_REPEAT;
         rep_cnt_ff <= RST_REPEAT;
         cnt_ff     <= RST_COUNT;
         dir_ff     <= 1'b0;
         flag_ff    <= 1'b0;
      end else begin
         if (wr_psc) psc_pre_ff <= wdata;
         if (wr_arr) arr_pre_ff <= wdata;
         if (wr_rep) rep_val_ff <= PWDATA_I[REP_W-1:0];
         // Shadow copies only on an update; unbuffered reload is direct
         if (update_event) begin
            psc_act_ff <= psc_pre_ff;
            arr_sh_ff  <= arr_pre_ff;
         end else if (wr_arr && !reload_buffer_enable_ff) begin
            arr_sh_ff <= wdata;
         end
         psc_cnt_ff <= nxt_psc_cnt;
         rep_cnt_ff <= nxt_rep_cnt;
         cnt_ff     <= nxt_cnt;
         dir_ff     <= nxt_dir;
         flag_ff    <= nxt_flag;
      end
   end

   // Event outputs are registered copies of the internal pulses
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         uev_ff   <= 1'b0;
         over_ff  <= 1'b0;
         under_ff <= 1'b0;
      end else begin
         uev_ff   <= update_event;
         over_ff  <= over;
         under_ff <= under;
      end
   end

   assign PRDATA_O         = rdata_ff;
   assign PREADY_O         = ready_ff;
   assign PSLVERR_O        = slverr_ff;
   assign UPDATE_EVENT_O   = uev_ff;
   assign UPDATE_FLAG_O    = flag_ff;
   assign OVERFLOW_O       = over_ff;
   assign UNDERFLOW_O      = under_ff;
   assign DIRECTION_O      = dir_ff;
   assign COUNTER_ACTIVE_O = active_ff;
   assign COUNT_VALUE_O    = cnt_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_run_rise;
      $rose(run_ff) ##0 !active_ff;
   endsequence
   sequence s_plain_under;
      under && !center && !force_req && !wr_count;
   endsequence
   run_delay_a: assert property (s_run_rise |=> active_ff)
      else $error("counter active did not follow run by one cycle");
   down_reload_a: assert property (
      s_plain_under |=> cnt_ff == $past(arr_new))
      else $error("down underflow did not reload the reload value");
   force_psc_a: assert property (
      force_req |=> psc_cnt_ff == '0 ##0 $stable(psc_act_ff) || uev_ff)
      else $error("forced update did not restart the prescaler");
   inhibit_hold_a: assert property (
      inhibit_ff && !(wr_arr && !reload_buffer_enable_ff)
      |=> !UPDATE_EVENT_O && $stable(arr_sh_ff) && $stable(psc_act_ff))
      else $error("update happened while inhibited");
   filter_force_a: assert property (
      force_req && filter_ff && !inhibit_ff && !flag_ff && !rep_event
      |=> UPDATE_EVENT_O && !UPDATE_FLAG_O)
      else $error("filtered forced update set the flag");
   shadow_copy_a: assert property (
      update_event |=> arr_sh_ff == $past(arr_pre_ff) &&
              psc_act_ff == $past(psc_pre_ff) && UPDATE_EVENT_O)
      else $error("update did not copy preloads");
   rep_gate_a: assert property (
      rep_event && !rep_zero && !force_req
      |=> !UPDATE_EVENT_O && rep_cnt_ff == $past(rep_cnt_ff) - 1'b1)
      else $error("update while repetition count not zero");
   rep_reload_a: assert property (
      force_req |=> rep_cnt_ff == $past(rep_val_ff))
      else $error("forced update did not reload repetition count");
   center_turn_a: assert property (
      center && over && !force_req && !wr_count
      |=> dir_ff && cnt_ff == $past(arr_m1) - 1'b1)
      else $error("center mode did not turn down at the top");
   dir_locked_a: assert property (
      center && wr_ctrl && !rep_event && !wr_count && !force_req
      |=> $stable(dir_ff))
      else $error("software changed direction in center mode");
   flag_wins_a: assert property (flag_set |=> UPDATE_FLAG_O)
      else $error("update flag set lost to a clear");

endmodule

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the timer time base: modes, repeat, events.
`timescale 1ns/10ps
`default_nettype none
module tb import timer_pkg::*;;
   // ------------------------------------------------------------
   // Signals and design instance
   // ------------------------------------------------------------
   logic        clk, reset_n, psel, penable, pwrite, tin, external_trigger_pin, itr, trg;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, upd, flag, ovf, unf, dir, act, e;
   logic [15:0] cnt;
   int          error_cnt, checked, seed, n_upd, n_ovf, g, k, p, r, n, m;

   timer_time_base u_timer_time_base (
      .CLK_I(clk), .RESET_N_I(reset_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .TIMER_INPUT_PIN_I(tin),
      .EXTERNAL_TRIGGER_PIN_I(external_trigger_pin), .INTERNAL_TRIGGER_IN_I(itr),
      .TRIGGER_UPDATE_I(trg), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .UPDATE_EVENT_O(upd), .UPDATE_FLAG_O(flag),
      .OVERFLOW_O(ovf), .UNDERFLOW_O(unf), .DIRECTION_O(dir),
      .COUNTER_ACTIVE_O(act), .COUNT_VALUE_O(cnt));

   // ------------------------------------------------------------
   // Clock, pulse counters, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Pulses are one cycle wide, so sample every edge
   always @(posedge clk) begin
      if (upd === 1'b1) n_upd++;
      if (ovf === 1'b1) n_ovf++;
   end

   // Longest run is far below this; a hang lands here
   initial begin
      repeat (50000) @(posedge clk);
      error_cnt++;
      stop_test;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   // Leading edge wait keeps psel from being assigned twice per step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function logic sig(input int s);
      sig = (s == 0) ? upd : (s == 1) ? ovf : unf;
   endfunction

   // Cycles between two successive pulses of one output
   task gap(input int s);
      g = 0;
      do @(posedge clk); while (sig(s) !== 1'b1);
      do begin
         @(posedge clk);
         g++;
      end while (sig(s) !== 1'b1);
   endtask

   function logic [31:0] ctl(input int run, inh, flt, dr, center_align_select, reload_buffer_enable);
      ctl = {24'h0, reload_buffer_enable[0], center_align_select[1:0], dr[0], 1'b0, flt[0], inh[0], run[0]};
   endfunction

   // Wrap spacing: center mode walks up and down over reload minus one
   function int per(input int m, p, r);
      per = (p + 1) * ((m == 2) ? 2 * (r - 1) : r + 1);
   endfunction

   function int ugap(input int m, p, r, n);
      ugap = (p + 1) * (n + 1) * ((m == 2) ? r - 1 : r + 1);
   endfunction

   task stop_test;
      if (error_cnt == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 76046;
      {reset_n, psel, penable, pwrite, tin, external_trigger_pin, itr, trg} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      apb(0, OFF_RELOAD, 0);
      chk(q, {16'h0, RST_RELOAD});
      apb(0, 8'h20, 0);
      chk({q[30:0], e}, 32'h1);
      // Each mode twice with random divider, reload and repeat count
      for (int i = 0; i < 6; i++) begin
         m = i % 3;
         p = $unsigned($random(seed)) % 3;
         r = 2 + $unsigned($random(seed)) % 8;
         n = $unsigned($random(seed)) % 3;
         apb(1, OFF_CONTROL_ONE, 0);
         apb(1, OFF_PRESCALE, p);
         apb(1, OFF_RELOAD, r);
         apb(1, OFF_REPEAT, n);
         apb(1, OFF_CONTROL_ONE, ctl(0, 0, 0, m == 1, m == 2, 0));
         apb(1, OFF_EVENT_TRIG, 1);
         #1 chk(cnt, (m == 1) ? r : 0);
         chk(dir, m == 1);
         apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, m == 1, m == 2, 0));
         @(posedge clk);
         #1 chk(act, 1);
         gap(m == 1 ? 2 : 1);
         chk(g, per(m, p, r));
         // Clear first so only a counter-driven update can set the flag
         apb(1, OFF_STATUS_ONE, 0);
         gap(0);
         chk(g, ugap(m, p, r, n));
         apb(0, OFF_STATUS_ONE, 0);
         chk(q[0], 1);
         chk(flag, 1);
      end
      // Still in center mode: count writes of reload and zero steer
      apb(1, OFF_COUNT, r);
      #1 chk(dir, 1);
      apb(1, OFF_COUNT, 0);
      #1 chk(dir, 0);
      // Buffered reload takes effect after the next wrap, not before
      apb(1, OFF_CONTROL_ONE, 0);
      apb(1, OFF_PRESCALE, 0);
      apb(1, OFF_REPEAT, 0);
      apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 1));
      apb(1, OFF_RELOAD, 5);
      gap(1);
      gap(1);
      chk(g, 6);
      // Inhibited: no update events, shadow keeps the old period
      apb(1, OFF_CONTROL_ONE, ctl(1, 1, 0, 0, 0, 1));
      apb(1, OFF_RELOAD, 2);
      k = n_upd;
      gap(1);
      gap(1);
      chk(g, 6);
      chk(n_upd, k);
      // Filtered forced update: event yes, flag no
      apb(1, OFF_CONTROL_ONE, ctl(0, 0, 1, 0, 0, 1));
      repeat (3) @(posedge clk);
      apb(1, OFF_STATUS_ONE, 0);
      k = n_upd;
      apb(1, OFF_EVENT_TRIG, 1);
      repeat (2) @(posedge clk);
      chk(n_upd, k + 1);
      apb(0, OFF_STATUS_ONE, 0);
      chk(q[0], 0);
      chk(flag, 0);
      // Update from the trigger controller in reset slave mode
      apb(1, OFF_SLAVE_MODE, SMS_RESET);
      k = n_upd;
      trg <= 1'b1;
      @(posedge clk);
      trg <= 1'b0;
      repeat (3) @(posedge clk);
      chk(n_upd, k + 1);
      // Each pin source as counting clock, reload now 2: three edges a wrap
      for (int s = 0; s < 3; s++) begin
         apb(1, OFF_SLAVE_MODE, (s == 0) ? 32'h8 : (s == 1) ? 32'h7 : 32'h17);
         apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 1));
         apb(1, OFF_EVENT_TRIG, 1);
         k = n_ovf;
         repeat (6) begin
            {itr, tin, external_trigger_pin} <= 3'h1 << s;
            repeat (4) @(posedge clk);
            {itr, tin, external_trigger_pin} <= 3'h0;
            repeat (4) @(posedge clk);
         end
         repeat (6) @(posedge clk);
         chk(n_ovf, k + 2);
      end
      stop_test;
   end
endmodule
`default_nettype wire
